// >>> design/apc_top.sv
`timescale 1ns/1ps
`include "apc_defs.svh"
module apc_top
    import apc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  vco_tick,
    input  wire logic [1:0]  cal_complete,
    input  wire logic [1:0]  lock_raw,
    output logic [1:0]       loop_cal_start,
    output logic             sys_cal_start,
    output logic [1:0]       out_clk,
    output logic [1:0]       fb_pulse,
    output logic [1:0]       multifunction_pin
);
    apc_byte_t  fbdiv [2];
    apc_byte_t  glob_cal;
    apc_byte_t  loop_cal [2];
    apc_byte_t  mfp_sel;
    apc_stat_s  stat [2];
    logic [3:0] events [2];
    logic [3:0] ev_clear [2];
    logic [1:0] cal_req;
    logic [13:0] idx;
    logic       access;
    logic       wr_go;
    logic       glob_go;
    apc_byte_t  next_rdata;
    logic       next_err;
    logic [2:0] sel0;
    logic [2:0] sel1;

    default clocking apc_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    assign idx    = paddr[15:2];
    assign access = psel & penable;
    // Write takes effect only on the completing edge
    assign wr_go  = access & pready & pwrite;

    // APB slave answers one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= access & ~pready;
    end

    always_comb
    begin
        next_rdata = 8'h00;
        next_err   = 1'b0;
        case (idx)
            `APC_IDX_L0_FBDIV:
                next_rdata = fbdiv[0];
            `APC_IDX_L1_FBDIV:
                next_rdata = fbdiv[1];
            `APC_IDX_GLOB_CAL:
                next_rdata = glob_cal;
            `APC_IDX_L0_CAL:
                next_rdata = loop_cal[0];
            `APC_IDX_L1_CAL:
                next_rdata = loop_cal[1];
            `APC_IDX_MFP_SEL:
                next_rdata = mfp_sel;
            `APC_IDX_L0_CLR, `APC_IDX_L1_CLR:
                next_rdata = 8'h00;
            `APC_IDX_L0_EVENTS:
                next_rdata = {4'h0, events[0]};
            `APC_IDX_L1_EVENTS:
                next_rdata = {4'h0, events[1]};
            `APC_IDX_L0_STATUS:
            begin
                next_rdata[`APC_ST_LOCK] = stat[0].locked;
                next_rdata[`APC_ST_BUSY] = stat[0].busy;
                next_rdata[`APC_ST_DONE] = stat[0].done;
            end
            `APC_IDX_L1_STATUS:
            begin
                next_rdata[`APC_ST_LOCK] = stat[1].locked;
                next_rdata[`APC_ST_BUSY] = stat[1].busy;
                next_rdata[`APC_ST_DONE] = stat[1].done;
            end
            default:
                next_err = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (access & ~pready)
        begin
            prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
            pslverr <= next_err;
        end
        else
        begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fbdiv[0] <= `APC_FBDIV_RESET;
            fbdiv[1] <= `APC_FBDIV_RESET;
        end
        else if (wr_go)
        begin
            if (idx == `APC_IDX_L0_FBDIV)
                fbdiv[0] <= pwdata[7:0];
            if (idx == `APC_IDX_L1_FBDIV)
                fbdiv[1] <= pwdata[7:0];
        end
    end

    // Trigger bits hold what software wrote
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            glob_cal    <= `APC_REG_RESET;
            loop_cal[0] <= `APC_REG_RESET;
            loop_cal[1] <= `APC_REG_RESET;
        end
        else if (wr_go)
        begin
            if (idx == `APC_IDX_GLOB_CAL)
                glob_cal <= pwdata[7:0];
            if (idx == `APC_IDX_L0_CAL)
                loop_cal[0] <= pwdata[7:0];
            if (idx == `APC_IDX_L1_CAL)
                loop_cal[1] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mfp_sel <= `APC_REG_RESET;
        else if (wr_go && idx == `APC_IDX_MFP_SEL)
            mfp_sel <= pwdata[7:0];
    end

    // Each write of a one starts a calibration
    assign glob_go    = wr_go & (idx == `APC_IDX_GLOB_CAL) & pwdata[`APC_CAL_BIT];
    assign cal_req[0] = glob_go | (wr_go & (idx == `APC_IDX_L0_CAL) & pwdata[`APC_CAL_BIT]);
    assign cal_req[1] = glob_go | (wr_go & (idx == `APC_IDX_L1_CAL) & pwdata[`APC_CAL_BIT]);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sys_cal_start <= 1'b0;
        else
            sys_cal_start <= glob_go;
    end

    // Write-one-to-clear strobes for the latched events
    assign ev_clear[0] = (wr_go && idx == `APC_IDX_L0_CLR) ? pwdata[3:0] : 4'h0;
    assign ev_clear[1] = (wr_go && idx == `APC_IDX_L1_CLR) ? pwdata[3:0] : 4'h0;

    genvar gl;
    generate
        for (gl = 0; gl < 2; gl++)
        begin : g_loop
            apc_loop u_loop
            (
                .pclk         (pclk),
                .presetn      (presetn),
                .start        (cal_req[gl]),
                .cal_complete (cal_complete[gl]),
                .lock_raw     (lock_raw[gl]),
                .clear        (ev_clear[gl]),
                .stat         (stat[gl]),
                .events       (events[gl]),
                .cal_start    (loop_cal_start[gl])
            );

            apc_fbdiv u_fbdiv
            (
                .pclk     (pclk),
                .presetn  (presetn),
                .vco_tick (vco_tick[gl]),
                .ratio    (fbdiv[gl]),
                .out_clk  (out_clk[gl]),
                .fb_pulse (fb_pulse[gl])
            );
        end
    endgenerate

    // Multifunction pin routing
    assign sel0 = mfp_sel[`APC_MFP0_LSB +: 3];
    assign sel1 = mfp_sel[`APC_MFP1_LSB +: 3];

    function automatic logic mfp_src(input logic [2:0] sel, input apc_stat_s s0, input apc_stat_s s1);
        logic v;
        v = 1'b0;
        case (sel)
            `APC_MFP_L0_BUSY:
                v = s0.busy;
            `APC_MFP_L1_BUSY:
                v = s1.busy;
            `APC_MFP_L0_LOCK:
                v = s0.locked;
            `APC_MFP_L1_LOCK:
                v = s1.locked;
            default:
                v = 1'b0;
        endcase
        return v;
    endfunction : mfp_src

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            multifunction_pin <= 2'b00;
        else
        begin
            multifunction_pin[0] <= mfp_src(sel0, stat[0], stat[1]);
            multifunction_pin[1] <= mfp_src(sel1, stat[0], stat[1]);
        end
    end

    AST_PREADY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pready) |=> pready ##1 !pready)
        else $error("pready not a single cycle");
    AST_GLOBAL_ALL: assert property (@(posedge pclk) disable iff (!presetn)
        glob_go |=> (sys_cal_start && loop_cal_start == 2'b11))
        else $error("global calibration missed a loop");
    AST_LOOP_ALONE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_go && idx == `APC_IDX_L0_CAL && pwdata[`APC_CAL_BIT]) |=>
        (loop_cal_start[0] && !loop_cal_start[1] && !sys_cal_start))
        else $error("loop calibration not isolated");
    AST_MFP_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
        (sel0 == `APC_MFP_L0_BUSY && $stable(sel0)) |=> (multifunction_pin[0] == $past(stat[0].busy)))
        else $error("pin does not follow busy");
    AST_MFP_LOCK: assert property (@(posedge pclk) disable iff (!presetn)
        (sel1 == `APC_MFP_L1_LOCK && $stable(sel1)) |=> (multifunction_pin[1] == $past(stat[1].locked)))
        else $error("pin does not follow lock");
    AST_STATUS_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pready && !pwrite && idx == `APC_IDX_L1_STATUS) |=>
        (prdata[`APC_ST_LOCK] == $past(stat[1].locked) && !pslverr))
        else $error("status read wrong");
    AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pready && next_err) |=> (pslverr && pready))
        else $error("unmapped access not flagged");
    COV_GLOBAL: cover property (@(posedge pclk) disable iff (!presetn) glob_go);
    COV_MFP_HIGH: cover property (@(posedge pclk) disable iff (!presetn) multifunction_pin[0]);
    COV_CLEAR_MEETS_LOSS: cover property (ev_clear[1][`APC_EV_LOCK_LOSS] && $fell(stat[1].locked));

    AST_READY_NEEDS_ACCESS: assert property (
        !access |=> !pready)
        else $error("ready without access");
    AST_ERR_WITH_READY: assert property (
        pslverr |-> pready)
        else $error("error without ready");
    AST_MAPPED_NO_ERR: assert property (
        (access && !pready && !next_err) |=> !pslverr)
        else $error("mapped access flagged");
    AST_RDATA_IDLE: assert property (
        !pready |-> (prdata == 32'h0000_0000))
        else $error("read data outside answer");
    AST_WRITE_READS_ZERO: assert property (
        (access && !pready && pwrite) |=> (prdata == 32'h0000_0000))
        else $error("write returned data");
    AST_CLR_READS_ZERO: assert property (
        (access && !pready && !pwrite && (idx == `APC_IDX_L0_CLR || idx == `APC_IDX_L1_CLR)) |=>
        (prdata == 32'h0000_0000 && !pslverr))
        else $error("clear register read not zero");

    AST_FBDIV0_LAND: assert property (
        (wr_go && idx == `APC_IDX_L0_FBDIV) |=> (fbdiv[0] == $past(pwdata[7:0])))
        else $error("divider 0 write lost");
    AST_FBDIV1_LAND: assert property (
        (wr_go && idx == `APC_IDX_L1_FBDIV) |=> (fbdiv[1] == $past(pwdata[7:0])))
        else $error("divider 1 write lost");
    AST_CAL0_HOLD: assert property (
        (wr_go && idx == `APC_IDX_L0_CAL) |=> (loop_cal[0] == $past(pwdata[7:0])))
        else $error("loop 0 trigger not stored");
    AST_CAL1_HOLD: assert property (
        (wr_go && idx == `APC_IDX_L1_CAL) |=> (loop_cal[1] == $past(pwdata[7:0])))
        else $error("loop 1 trigger not stored");
    AST_GLOB_HOLD: assert property (
        (wr_go && idx == `APC_IDX_GLOB_CAL) |=> (glob_cal == $past(pwdata[7:0])))
        else $error("global trigger not stored");

    AST_LOOP1_ALONE: assert property (
        (wr_go && idx == `APC_IDX_L1_CAL && pwdata[`APC_CAL_BIT]) |=>
        (loop_cal_start[1] && !loop_cal_start[0] && !sys_cal_start))
        else $error("loop 1 calibration not isolated");
    AST_SYS_ONLY_GLOBAL: assert property (
        !glob_go |=> !sys_cal_start)
        else $error("system calibration without global write");
    AST_NO_REQ_NO_START: assert property (
        (cal_req == 2'b00) |=> (loop_cal_start == 2'b00))
        else $error("loop calibration without request");

    AST_MFP0_OFF: assert property (
        (sel0 == `APC_MFP_OFF) |=> !multifunction_pin[0])
        else $error("pin 0 driven while off");
    AST_MFP1_OFF: assert property (
        (sel1 == `APC_MFP_OFF) |=> !multifunction_pin[1])
        else $error("pin 1 driven while off");
    AST_MFP_UNUSED: assert property (
        (sel0 > `APC_MFP_L1_LOCK) |=> !multifunction_pin[0])
        else $error("pin 0 driven by unused code");
    AST_MFP_L1_BUSY: assert property (
        (sel0 == `APC_MFP_L1_BUSY) |=> (multifunction_pin[0] == $past(stat[1].busy)))
        else $error("pin does not follow loop 1 busy");
    AST_MFP_L0_LOCK: assert property (
        (sel1 == `APC_MFP_L0_LOCK) |=> (multifunction_pin[1] == $past(stat[0].locked)))
        else $error("pin does not follow loop 0 lock");

    AST_STATUS0_READ: assert property (
        (access && !pready && !pwrite && idx == `APC_IDX_L0_STATUS) |=>
        (prdata[`APC_ST_BUSY] == $past(stat[0].busy) && prdata[`APC_ST_DONE] == $past(stat[0].done)))
        else $error("status 0 read wrong");
    AST_EVENTS0_READ: assert property (
        (access && !pready && !pwrite && idx == `APC_IDX_L0_EVENTS) |=> (prdata[3:0] == $past(events[0])))
        else $error("events 0 read wrong");
    AST_EVENTS1_READ: assert property (
        (access && !pready && !pwrite && idx == `APC_IDX_L1_EVENTS) |=> (prdata[3:0] == $past(events[1])))
        else $error("events 1 read wrong");
endmodule : apc_top

// >>> design/apc_defs.svh
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH

// Register indices; byte address is four times the index
`define APC_IDX_L0_FBDIV   14'h1081
`define APC_IDX_L1_FBDIV   14'h1481
`define APC_IDX_GLOB_CAL   14'h2000
`define APC_IDX_L0_CLR     14'h200f
`define APC_IDX_L1_CLR     14'h2014
`define APC_IDX_L0_CAL     14'h2100
`define APC_IDX_L1_CAL     14'h2200
`define APC_IDX_MFP_SEL    14'h2300
`define APC_IDX_L0_EVENTS  14'h3014
`define APC_IDX_L1_EVENTS  14'h3019
`define APC_IDX_L0_STATUS  14'h3100
`define APC_IDX_L1_STATUS  14'h3200

`define APC_CAL_BIT        1
`define APC_ST_LOCK        3
`define APC_ST_BUSY        4
`define APC_ST_DONE        5
`define APC_EV_BUSY        0
`define APC_EV_DONE        1
`define APC_EV_LOCK_GAIN   2
`define APC_EV_LOCK_LOSS   3

// Multifunction pin source codes, pin 0 in [2:0], pin 1 in [6:4]
`define APC_MFP0_LSB       0
`define APC_MFP1_LSB       4
`define APC_MFP_OFF        3'h0
`define APC_MFP_L0_BUSY    3'h1
`define APC_MFP_L1_BUSY    3'h2
`define APC_MFP_L0_LOCK    3'h3
`define APC_MFP_L1_LOCK    3'h4

`define APC_REG_RESET      8'h00
`define APC_FBDIV_RESET    8'h01
`endif

// >>> design/apc_pkg.sv
package apc_pkg;
    typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} apc_cal_e;

    typedef struct packed {
        logic locked;
        logic busy;
        logic done;
    } apc_stat_s;

    typedef logic [7:0] apc_byte_t;
endpackage : apc_pkg

// >>> design/apc_loop.sv
`timescale 1ns/1ps
`include "apc_defs.svh"
module apc_loop
    import apc_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       start,
    input  wire logic       cal_complete,
    input  wire logic       lock_raw,
    input  wire logic [3:0] clear,
    output apc_stat_s       stat,
    output logic [3:0]      events,
    output logic            cal_start
);
    apc_cal_e   state;
    logic       busy;
    logic       done;
    logic       locked;
    logic       busy_q;
    logic       done_q;
    logic       locked_q;
    logic [3:0] set_ev;

    assign stat = '{locked: locked, busy: busy, done: done};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= CAL_IDLE;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else
        begin
            case (state)
                CAL_IDLE, CAL_DONE:
                begin
                    if (start)
                    begin
                        state <= CAL_RUN;
                        busy  <= 1'b1;
                        done  <= 1'b0;
                    end
                end
                CAL_RUN:
                begin
                    if (cal_complete)
                    begin
                        state <= CAL_DONE;
                        busy  <= 1'b0;
                        done  <= 1'b1;
                    end
                end
                default:
                begin
                    state <= CAL_IDLE;
                    busy  <= 1'b0;
                    done  <= 1'b0;
                end
            endcase
        end
    end

    // Request to the analog band search
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cal_start <= 1'b0;
        else
            cal_start <= start;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            locked   <= 1'b0;
            busy_q   <= 1'b0;
            done_q   <= 1'b0;
            locked_q <= 1'b0;
        end
        else
        begin
            locked   <= lock_raw;
            busy_q   <= busy;
            done_q   <= done;
            locked_q <= locked;
        end
    end

    assign set_ev[`APC_EV_BUSY]      = busy & ~busy_q;
    assign set_ev[`APC_EV_DONE]      = done & ~done_q;
    assign set_ev[`APC_EV_LOCK_GAIN] = locked & ~locked_q;
    assign set_ev[`APC_EV_LOCK_LOSS] = ~locked & locked_q;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_ev
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                    events[gi] <= 1'b0;
                else
                    events[gi] <= set_ev[gi] | (events[gi] & ~clear[gi]);
            end
        end
    endgenerate

    AST_BUSY_DONE_EXCL: assert property (@(posedge pclk) disable iff (!presetn) !(busy && done))
        else $error("busy and done both high");
    AST_EV_SET_WINS: assert property (@(posedge pclk) disable iff (!presetn)
        (set_ev[`APC_EV_LOCK_LOSS] && clear[`APC_EV_LOCK_LOSS]) |=> events[`APC_EV_LOCK_LOSS])
        else $error("event lost under clear");
    AST_LOCK_GAIN_EV: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(locked) |=> events[`APC_EV_LOCK_GAIN])
        else $error("lock gain not latched");
    AST_CLEAR_EV: assert property (@(posedge pclk) disable iff (!presetn)
        (clear[`APC_EV_DONE] && !set_ev[`APC_EV_DONE]) |=> !events[`APC_EV_DONE])
        else $error("done event not cleared");
    AST_START_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
        (start && !busy) |=> (busy && cal_start) ##1 events[`APC_EV_BUSY])
        else $error("start did not raise busy and its event");
    COV_CAL_DONE: cover property (@(posedge pclk) disable iff (!presetn) busy ##[1:50] done);
    COV_LOCK_LOSS: cover property (@(posedge pclk) disable iff (!presetn) $fell(locked));
endmodule : apc_loop

// >>> design/apc_fbdiv.sv
`timescale 1ns/1ps
module apc_fbdiv
    import apc_pkg::*;
(
    input  wire logic      pclk,
    input  wire logic      presetn,
    input  wire logic      vco_tick,
    input  wire apc_byte_t ratio,
    output logic           out_clk,
    output logic           fb_pulse
);
    apc_byte_t eff;
    apc_byte_t cnt;
    logic      out_rise;

    assign eff      = (ratio == 8'h00) ? 8'h01 : ratio;
    assign out_rise = vco_tick & ~out_clk;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_clk <= 1'b0;
        else
            out_clk <= out_clk ^ vco_tick;
    end

    // One feedback pulse per eff output periods
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt      <= 8'h00;
            fb_pulse <= 1'b0;
        end
        else if (out_rise)
        begin
            if (cnt >= eff - 8'h01)
            begin
                cnt      <= 8'h00;
                fb_pulse <= 1'b1;
            end
            else
            begin
                cnt      <= cnt + 8'h01;
                fb_pulse <= 1'b0;
            end
        end
        else
            fb_pulse <= 1'b0;
    end

    AST_DIV_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        (out_rise && eff == 8'h01) |=> fb_pulse)
        else $error("ratio one missed a pulse");
    AST_HALF_RATE: assert property (@(posedge pclk) disable iff (!presetn)
        vco_tick |=> (out_clk != $past(out_clk)))
        else $error("output stage did not toggle");
endmodule : apc_fbdiv

// >>> test/analog_pll_cal_lock_status_tb_top.sv
`timescale 1ns/1ps
`include "apc_defs.svh"
module analog_pll_cal_lock_status_tb_top;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  vco_tick;
    logic [1:0]  cal_complete;
    logic [1:0]  lock_raw;
    logic [1:0]  loop_cal_start;
    logic        sys_cal_start;
    logic [1:0]  out_clk;
    logic [1:0]  fb_pulse;
    logic [1:0]  multifunction_pin;
    logic [31:0] rd;
    logic        err;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;

    apc_top dut (
        .pclk              (pclk),
        .presetn           (presetn),
        .psel              (psel),
        .penable           (penable),
        .pwrite            (pwrite),
        .paddr             (paddr),
        .pwdata            (pwdata),
        .prdata            (prdata),
        .pready            (pready),
        .pslverr           (pslverr),
        .vco_tick          (vco_tick),
        .cal_complete      (cal_complete),
        .lock_raw          (lock_raw),
        .loop_cal_start    (loop_cal_start),
        .sys_cal_start     (sys_cal_start),
        .out_clk           (out_clk),
        .fb_pulse          (fb_pulse),
        .multifunction_pin (multifunction_pin)
    );

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : end_sim

    // Hang guard
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr_en, input logic [13:0] idx, input logic [7:0] wd,
                       output logic [31:0] rdata, output logic serr);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        serr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [13:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, rd, err);
    endtask : wr

    task automatic rdc(input string what, input logic [13:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, rd, err);
        chk(what, {24'h000000, exp}, rd);
    endtask : rdc

    task automatic t_reset;
        rdc("div0 reset", `APC_IDX_L0_FBDIV, 8'h01);
        rdc("div1 reset", `APC_IDX_L1_FBDIV, 8'h01);
        rdc("status0 reset", `APC_IDX_L0_STATUS, 8'h00);
        rdc("events1 reset", `APC_IDX_L1_EVENTS, 8'h00);
        apb(1'b1, 14'h0123, 8'h55, rd, err);
        chk("unmapped wr err", 32'h1, {31'h0, err});
        apb(1'b0, 14'h0123, 8'h00, rd, err);
        chk("unmapped rd err", 32'h1, {31'h0, err});
        wr(`APC_IDX_L0_EVENTS, 8'hff);
        rdc("events0 read only", `APC_IDX_L0_EVENTS, 8'h00);
    endtask : t_reset

    task automatic t_loop_cal;
        wr(`APC_IDX_MFP_SEL, 8'h41);
        wr(`APC_IDX_L0_CAL, 8'h02);
        @(posedge pclk);
        chk("loop start", 32'h1, {30'h0, loop_cal_start});
        chk("sys start", 32'h0, {31'h0, sys_cal_start});
        @(posedge pclk);
        chk("loop start pulse", 32'h0, {30'h0, loop_cal_start});
        rdc("cal0 held", `APC_IDX_L0_CAL, 8'h02);
        wr(`APC_IDX_L0_CAL, 8'h00);
        rdc("cal0 zero", `APC_IDX_L0_CAL, 8'h00);
        chk("pin0 busy", 32'h1, {31'h0, multifunction_pin[0]});
        rdc("status0 busy", `APC_IDX_L0_STATUS, 8'h10);
        rdc("status1 idle", `APC_IDX_L1_STATUS, 8'h00);
        cal_complete <= 2'b01;
        @(posedge pclk);
        cal_complete <= 2'b00;
        rdc("status0 done", `APC_IDX_L0_STATUS, 8'h20);
        chk("pin0 idle", 32'h0, {31'h0, multifunction_pin[0]});
        rdc("events0 cal", `APC_IDX_L0_EVENTS, 8'h03);
        wr(`APC_IDX_L0_CLR, 8'h01);
        rdc("events0 part clr", `APC_IDX_L0_EVENTS, 8'h02);
        wr(`APC_IDX_L0_CLR, 8'h02);
        rdc("events0 clr", `APC_IDX_L0_EVENTS, 8'h00);
        rdc("clr0 reads zero", `APC_IDX_L0_CLR, 8'h00);
    endtask : t_loop_cal

    task automatic t_global;
        wr(`APC_IDX_GLOB_CAL, 8'h02);
        @(posedge pclk);
        chk("glob loop start", 32'h3, {30'h0, loop_cal_start});
        chk("glob sys start", 32'h1, {31'h0, sys_cal_start});
        wr(`APC_IDX_GLOB_CAL, 8'h00);
        rdc("status0 busy", `APC_IDX_L0_STATUS, 8'h10);
        rdc("status1 busy", `APC_IDX_L1_STATUS, 8'h10);
        lock_raw <= 2'b01;
        wr(`APC_IDX_MFP_SEL, 8'h32);
        repeat (2) @(posedge pclk);
        chk("pin0 loop1 busy", 32'h1, {31'h0, multifunction_pin[0]});
        chk("pin1 loop0 lock", 32'h1, {31'h0, multifunction_pin[1]});
        lock_raw <= 2'b00;
        wr(`APC_IDX_MFP_SEL, 8'h41);
        cal_complete <= 2'b11;
        @(posedge pclk);
        cal_complete <= 2'b00;
        rdc("status1 done", `APC_IDX_L1_STATUS, 8'h20);
        rdc("events1 cal", `APC_IDX_L1_EVENTS, 8'h03);
        wr(`APC_IDX_L0_CLR, 8'h0f);
        wr(`APC_IDX_L1_CLR, 8'h03);
        rdc("events1 clr", `APC_IDX_L1_EVENTS, 8'h00);
    endtask : t_global

    task automatic t_lock;
        lock_raw <= 2'b10;
        rdc("status1 lock", `APC_IDX_L1_STATUS, 8'h28);
        chk("pin1 lock", 32'h1, {31'h0, multifunction_pin[1]});
        rdc("events1 gain", `APC_IDX_L1_EVENTS, 8'h04);
        rdc("events0 quiet", `APC_IDX_L0_EVENTS, 8'h00);
        lock_raw <= 2'b00;
        rdc("status1 unlock", `APC_IDX_L1_STATUS, 8'h20);
        chk("pin1 unlock", 32'h0, {31'h0, multifunction_pin[1]});
        rdc("events1 loss", `APC_IDX_L1_EVENTS, 8'h0c);
        wr(`APC_IDX_L1_CLR, 8'h04);
        rdc("events1 part clr", `APC_IDX_L1_EVENTS, 8'h08);
        wr(`APC_IDX_L1_CLR, 8'h08);
        rdc("events1 clr", `APC_IDX_L1_EVENTS, 8'h00);
        lock_raw <= 2'b10;
        rdc("events1 regain", `APC_IDX_L1_EVENTS, 8'h04);
        // Lock loss lands in the same cycle as the clear strobe
        fork
            wr(`APC_IDX_L1_CLR, 8'h0c);
            begin
                repeat (2) @(posedge pclk);
                lock_raw <= 2'b00;
            end
        join
        rdc("events1 loss kept", `APC_IDX_L1_EVENTS, 8'h08);
        wr(`APC_IDX_L1_CLR, 8'h08);
        rdc("events1 clr again", `APC_IDX_L1_EVENTS, 8'h00);
    endtask : t_lock

    // Pulse spacing in cycles with a tick every cycle
    task automatic t_div(input int lp, input logic [7:0] d);
        int   n;
        logic o;
        wr(lp == 0 ? `APC_IDX_L0_FBDIV : `APC_IDX_L1_FBDIV, d);
        rdc("div readback", lp == 0 ? `APC_IDX_L0_FBDIV : `APC_IDX_L1_FBDIV, d);
        vco_tick <= 2'b11;
        repeat (2) do @(posedge pclk); while (fb_pulse[lp] !== 1'b1);
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (fb_pulse[lp] !== 1'b1);
        chk("fb gap", 2 * (d == 8'h00 ? 1 : d), n);
        o = out_clk[lp];
        @(posedge pclk);
        chk("out clk toggles", {31'h0, ~o}, {31'h0, out_clk[lp]});
        vco_tick <= 2'b00;
        repeat (2) @(posedge pclk);
        o = out_clk[lp];
        @(posedge pclk);
        chk("out clk still", {31'h0, o}, {31'h0, out_clk[lp]});
    endtask : t_div

    initial
    begin
        presetn      = 1'b0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 16'h0000;
        pwdata       = 32'h00000000;
        vco_tick     = 2'b00;
        cal_complete = 2'b00;
        lock_raw     = 2'b00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_loop_cal();
        t_global();
        t_lock();
        t_div(0, 8'h00);
        t_div(0, 8'h01);
        t_div(0, 8'h03);
        t_div(0, 8'hff);
        t_div(1, 8'h1b);
        end_sim();
    end
endmodule : analog_pll_cal_lock_status_tb_top
